// *** seic_pkg.sv ***
// seic_pkg: constants and types for the system event interrupt control.
// assumes a single 10 MHz core clock and a 32-bit AHB-Lite register bus.
// Function
// R1 - only enabled sources reach the interrupt
// R2 - software reads raw or masked view
// R3 - seven separate clock and power event sources
// R4 - handler must clear the causing source
// R5 - clear mask write clears selected events
// R6 - check enable runs oscillator loss detector (code holds it off while the power-off setting is set)
// R7 - failure response: interrupt or processor reset
// R8 - no-crystal setting lowers oscillator power
// R9 - power-off setting unpowers oscillator input
// R10 - range setting: below or above 10 MHz
// R11 - single-ended setting selects one-pin clock input
// R12 - six non-maskable status flags kept
// R13 - nmi clear mask clears only selected flags
// R14 - nmi flags readable as one field
// R15 - irq when any raw AND enable bit
package seic_pkg;

   localparam int unsigned EVT_W = 7;
   localparam int unsigned NMI_W = 6;
   localparam int unsigned CFG_W = 7;
   localparam int unsigned AW    = 6;

   // register byte offsets, low address bits
   localparam logic [AW-1:0] OFF_STATUS  = 6'h00;
   localparam logic [AW-1:0] OFF_ENABLE  = 6'h04;
   localparam logic [AW-1:0] OFF_MASKED  = 6'h08;
   localparam logic [AW-1:0] OFF_VIEW    = 6'h0C;
   localparam logic [AW-1:0] OFF_OSC_CFG = 6'h10;
   localparam logic [AW-1:0] OFF_NMI     = 6'h14;

   // oscillator configuration bit positions
   localparam int unsigned CFG_CHECK  = 0;
   localparam int unsigned CFG_IRQSEL = 1;
   localparam int unsigned CFG_NOXTAL = 2;
   localparam int unsigned CFG_PWROFF = 3;
   localparam int unsigned CFG_LOW    = 4;
   localparam int unsigned CFG_HIGH   = 5;
   localparam int unsigned CFG_SE     = 6;

   // event and nmi bit positions
   localparam int unsigned EVT_MAIN_OSCILLATOR_FAIL = 3;
   localparam int unsigned NMI_MAIN_OSCILLATOR      = 0;

   // reset values
   localparam logic [EVT_W-1:0] EVT_RST  = 7'h00;
   localparam logic [NMI_W-1:0] NMI_RST  = 6'h00;
   localparam logic             RANGE_RST = 1'b0;
   localparam logic             VIEW_RST  = 1'b0;
   localparam logic [CFG_W-1:0] CFG_RST   = 7'h00;

   // loss of clock window
   localparam int unsigned CLK_PERIOD_NS = 100;
   localparam int unsigned MISS_TIME_NS  = 1000;
   localparam int unsigned MISS_CYCLES   =
      (MISS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned MISS_W = 12;

   localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

   typedef enum logic [3:0] {
      SEIC_IDLE  = 4'b0001,
      SEIC_WRITE = 4'b0010,
      SEIC_RWAIT = 4'b0100,
      SEIC_RDONE = 4'b1000
   } seic_bus_e;

endpackage

// *** seic_top.sv ***
// seic_top: event status, enables, nmi flags, oscillator control, ahb slave.
// assumes hsel decodes the block's window and inputs are core_clk synchronous.
`timescale 1ns/10ps
module seic_top
   import seic_pkg::*;
#(
   parameter int unsigned MISS_LIMIT = MISS_CYCLES
) (
   input  wire logic             core_clk,
   input  wire logic             srst,
   input  wire logic             hsel,
   input  wire logic [31:0]      haddr,
   input  wire logic [1:0]       htrans,
   input  wire logic             hwrite,
   input  wire logic [2:0]       hsize,
   input  wire logic [31:0]      hwdata,
   input  wire logic             hready,
   output logic      [31:0]      hrdata,
   output logic                  hreadyout,
   output logic                  hresp,
   input  wire logic             pll_locked_event,
   input  wire logic             regulator_current_limit_event,
   input  wire logic             internal_osc_fail_event,
   input  wire logic             regulator_droop_event,
   input  wire logic             supply_droop_event,
   input  wire logic             pll_failure_event,
   input  wire logic             main_osc_tick,
   input  wire logic             nmi_tamper_in,
   input  wire logic             nmi_watchdog_zero_in,
   input  wire logic             nmi_watchdog_one_in,
   input  wire logic             nmi_power_in,
   input  wire logic             nmi_pin_in,
   output logic                  sys_irq,
   output logic                  nmi_req,
   output logic                  main_osc_reset_req,
   output logic                  main_osc_power_off,
   output logic                  main_osc_low_power,
   output logic                  main_osc_high_range,
   output logic                  single_ended_clock_select
);

   function automatic logic hit(input logic [AW-1:0] a,
                                input logic [AW-1:0] off);
      hit = (a == off);
   endfunction

   // zero-extend an event-wide field to a bus word
   function automatic logic [31:0] evt_word(input logic [EVT_W-1:0] v);
      evt_word = {{(32-EVT_W){1'b0}}, v};
   endfunction

   seic_bus_e         state_reg;
   seic_bus_e         state_next;
   logic [AW-1:0]     addr_reg;
   logic [31:0]       rdata_reg;
   logic [EVT_W-1:0]  raw_reg;
   logic [EVT_W-1:0]  raw_next;
   logic [EVT_W-1:0]  en_reg;
   logic              view_reg;
   logic [CFG_W-1:0]  cfg_reg;
   logic              range_reg;
   logic              range_next;
   logic [NMI_W-1:0]  nmi_reg;
   logic [NMI_W-1:0]  nmi_next;
   logic [MISS_W-1:0] miss_reg;
   logic [MISS_W-1:0] miss_next;
   logic              lost_reg;
   logic              rst_req_reg;

   // bus decode
   wire logic accept   = hsel & hready & htrans[1];
   wire logic in_write = (state_reg == SEIC_WRITE);
   wire logic wr_stat  = in_write & hit(addr_reg, OFF_STATUS);
   wire logic wr_en    = in_write & hit(addr_reg, OFF_ENABLE);
   wire logic wr_view  = in_write & hit(addr_reg, OFF_VIEW);
   wire logic wr_cfg   = in_write & hit(addr_reg, OFF_OSC_CFG);
   wire logic wr_nmi   = in_write & hit(addr_reg, OFF_NMI);

   // masked view is the raw status gated by the enables
   wire logic [EVT_W-1:0] masked = raw_reg & en_reg; // R15 R1
   wire logic [EVT_W-1:0] view   = view_reg ? masked : raw_reg; // R2

   // oscillator settings decode
   wire logic chk_on  = cfg_reg[CFG_CHECK] & ~cfg_reg[CFG_PWROFF];
   wire logic irq_sel = cfg_reg[CFG_IRQSEL];
   // counter parked at its top means a full window passed with no tick
   wire logic at_limit = (miss_reg == MISS_W'(MISS_LIMIT - 1));
   wire logic miss_hit = chk_on & ~lost_reg & ~main_osc_tick & at_limit;
   wire logic fail_irq = miss_hit & irq_sel; // R7
   wire logic fail_rst = miss_hit & ~irq_sel; // R7

   // event sets
   wire logic [EVT_W-1:0] evt_set = {
      pll_failure_event,
      supply_droop_event,
      regulator_droop_event,
      fail_irq,
      internal_osc_fail_event,
      regulator_current_limit_event,
      pll_locked_event
   }; // R3

   wire logic [NMI_W-1:0] nmi_set = {
      nmi_pin_in,
      nmi_power_in,
      nmi_watchdog_one_in,
      nmi_watchdog_zero_in,
      nmi_tamper_in,
      miss_hit
   }; // R12

   wire logic [EVT_W-1:0] evt_clr =
      wr_stat ? hwdata[EVT_W-1:0] : EVT_RST;
   wire logic [NMI_W-1:0] nmi_clr =
      wr_nmi ? hwdata[NMI_W-1:0] : NMI_RST;

   // set beats clear so an event in the clear cycle survives
   assign raw_next = (raw_reg & ~evt_clr) | evt_set; // R5
   assign nmi_next = (nmi_reg & ~nmi_clr) | nmi_set; // R13

   // range: high bit wins if both written as one
   always_comb begin
      range_next = range_reg;
      if (wr_cfg & hwdata[CFG_HIGH]) begin
         range_next = 1'b1; // R10
      end else if (wr_cfg & hwdata[CFG_LOW]) begin
         range_next = 1'b0; // R10
      end
   end

   // loss detector counts cycles since the last oscillator tick
   always_comb begin
      miss_next = miss_reg;
      if (~chk_on | main_osc_tick) begin
         miss_next = '0;
      end else if (~at_limit) begin
         miss_next = miss_reg + MISS_W'(1); // R6
      end
   end

   // read mux
   wire logic [31:0] rd_stat = evt_word(view);
   wire logic [31:0] rd_en   = evt_word(en_reg);
   wire logic [31:0] rd_mask = evt_word(masked);
   wire logic [31:0] rd_view = {{31{1'b0}}, view_reg};
   wire logic [31:0] rd_nmi  = {{(32-NMI_W){1'b0}}, nmi_reg}; // R14
   wire logic [CFG_W-1:0] cfg_view = {
      cfg_reg[CFG_SE],
      range_reg,
      ~range_reg,
      cfg_reg[CFG_PWROFF:CFG_CHECK]
   };
   wire logic [31:0] rd_cfg  = {{(32-CFG_W){1'b0}}, cfg_view};
   wire logic [31:0] rd_word =
      hit(addr_reg, OFF_STATUS)  ? rd_stat :
      hit(addr_reg, OFF_ENABLE)  ? rd_en   :
      hit(addr_reg, OFF_MASKED)  ? rd_mask :
      hit(addr_reg, OFF_VIEW)    ? rd_view :
      hit(addr_reg, OFF_OSC_CFG) ? rd_cfg  :
      hit(addr_reg, OFF_NMI)     ? rd_nmi  : ZERO_WORD;

   // bus sequencing; reads take one wait state so hrdata is a flop
   always_comb begin
      state_next = SEIC_IDLE;
      unique case (state_reg)
         SEIC_RWAIT: begin
            state_next = SEIC_RDONE;
         end
         SEIC_IDLE, SEIC_WRITE, SEIC_RDONE: begin
            if (accept) begin
               state_next = hwrite ? SEIC_WRITE : SEIC_RWAIT;
            end
         end
         default: begin
            state_next = SEIC_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         state_reg <= SEIC_IDLE;
         addr_reg  <= '0;
         rdata_reg <= ZERO_WORD;
      end else begin
         state_reg <= state_next;
         if (accept & (state_reg != SEIC_RWAIT)) begin
            addr_reg <= haddr[AW-1:0];
         end
         if (state_reg == SEIC_RWAIT) begin
            rdata_reg <= rd_word;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         raw_reg  <= EVT_RST;
         nmi_reg  <= NMI_RST;
      end else begin
         raw_reg  <= raw_next; // R3
         nmi_reg  <= nmi_next; // R12
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         en_reg   <= EVT_RST;
         view_reg <= VIEW_RST;
      end else begin
         if (wr_en) begin
            en_reg <= hwdata[EVT_W-1:0]; // R1
         end
         if (wr_view) begin
            view_reg <= hwdata[0]; // R2
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         cfg_reg   <= CFG_RST;
         range_reg <= RANGE_RST;
      end else begin
         range_reg <= range_next;
         if (wr_cfg) begin
            cfg_reg <= hwdata[CFG_W-1:0]; // R6 R7 R8 R9 R11
         end
      end
   end

   // lost flag stops repeated reports until the clock comes back
   always_ff @(posedge core_clk) begin
      if (srst) begin
         miss_reg    <= '0;
         lost_reg    <= 1'b0;
         rst_req_reg <= 1'b0;
      end else begin
         miss_reg    <= miss_next;
         rst_req_reg <= fail_rst; // R7
         if (~chk_on | main_osc_tick) begin
            lost_reg <= 1'b0;
         end else if (miss_hit) begin
            lost_reg <= 1'b1; // R6
         end
      end
   end

   assign hrdata    = rdata_reg;
   assign hreadyout = (state_reg != SEIC_RWAIT);
   assign hresp     = 1'b0;

   assign sys_irq = |masked; // R15 R1
   assign nmi_req = |nmi_reg;
   assign main_osc_reset_req = rst_req_reg;

   // oscillator analog controls straight from the settings
   assign main_osc_power_off  = cfg_reg[CFG_PWROFF]; // R9
   assign main_osc_low_power  = cfg_reg[CFG_NOXTAL]; // R8
   assign main_osc_high_range = range_reg; // R10
   assign single_ended_clock_select = cfg_reg[CFG_SE]; // R11

   // hsize is unused: every register is a whole word
   wire logic unused_ok = &{1'b0, hsize, haddr[31:AW], htrans[0]};

endmodule

// *** seic_properties.sv ***
// seic_properties: port-level checks for seic_top.
// assumes hready is fed back from hreadyout.
`timescale 1ns/10ps
module seic_properties
   import seic_pkg::*;
#(
   parameter int unsigned MISS_LIMIT = MISS_CYCLES
) (
   input wire logic       core_clk,
   input wire logic       srst,
   input wire logic       hsel,
   input wire logic [1:0] htrans,
   input wire logic       hwrite,
   input wire logic       hready,
   input wire logic       hreadyout,
   input wire logic       nmi_tamper_in,
   input wire logic       main_osc_tick,
   input wire logic       sys_irq,
   input wire logic       nmi_req,
   input wire logic       main_osc_reset_req,
   input wire logic       main_osc_power_off
);
   logic take;
   logic wr_d;
   assign take = hsel && hready && htrans[1];
   // only a register write may lower a sticky output
   always_ff @(posedge core_clk) wr_d <= take && hwrite && !srst;
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);
   AST_RESET_QUIET: assert property (disable iff (1'b0)
      srst |=> !sys_irq && !nmi_req && hreadyout)
      else $error("outputs not quiet after reset");
   AST_IRQ_FALL: assert property (
      $fell(sys_irq) && !$past(srst) |-> $past(wr_d))
      else $error("irq dropped without a write");
   AST_NMI_SET: assert property (nmi_tamper_in |=> nmi_req)
      else $error("tamper flag not raised");
   AST_NMI_FALL: assert property (
      $fell(nmi_req) && !$past(srst) |-> $past(wr_d))
      else $error("nmi dropped without a write");
   AST_READ_WAIT: assert property (
      take && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   AST_REQ_PULSE: assert property (
      main_osc_reset_req |=> !main_osc_reset_req)
      else $error("reset request longer than one cycle");
   AST_TICK_HOLD: assert property (
      main_osc_tick |-> ##2 !main_osc_reset_req)
      else $error("loss reported with clock alive");
   AST_PWR_QUIET: assert property (
      main_osc_power_off && $past(main_osc_power_off, 3)
      |-> !main_osc_reset_req)
      else $error("loss reported while powered off");
   AST_COV_READ: cover property (take && !hwrite);
   AST_COV_IRQ: cover property ($rose(sys_irq));
   AST_COV_REQ: cover property (main_osc_reset_req);
endmodule

bind seic_top seic_properties #(.MISS_LIMIT(MISS_LIMIT)) u_props (
   .core_clk           (core_clk),
   .srst               (srst),
   .hsel               (hsel),
   .htrans             (htrans),
   .hwrite             (hwrite),
   .hready             (hready),
   .hreadyout          (hreadyout),
   .nmi_tamper_in      (nmi_tamper_in),
   .main_osc_tick      (main_osc_tick),
   .sys_irq            (sys_irq),
   .nmi_req            (nmi_req),
   .main_osc_reset_req (main_osc_reset_req),
   .main_osc_power_off (main_osc_power_off)
);

// *** seic_cpu_model.sv ***
// seic_cpu_model: processor-side interrupt controller stand-in.
// assumes a level irq held until the handler clears its source.
`timescale 1ns/10ps
module seic_cpu_model (
   input  wire logic       core_clk,
   input  wire logic       srst,
   input  wire logic       sys_irq,
   output logic      [7:0] irq_cnt
);
   logic irq_q;
   // level input: count handler entries, not busy cycles
   always_ff @(posedge core_clk) begin
      irq_q   <= sys_irq && !srst;
      irq_cnt <= srst ? 8'h00 : irq_cnt + 8'(sys_irq && !irq_q);
   end
endmodule

// *** tb_system_event_interrupt_control.sv ***
// tb_system_event_interrupt_control: bus-level tests of seic_top.
// assumes one ahb slave, hready fed back from hreadyout.
`timescale 1ns/10ps
module tb_system_event_interrupt_control
   import seic_pkg::*;
;
   localparam logic [31:0] ONE = 32'h0000_0001;
   logic        core_clk, srst, hsel, hwrite, main_osc_tick, osc_run, rdy_n;
   logic [31:0] haddr, hwdata, hrdata, hr_n;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [6:0]  ev;
   logic [5:0]  nm;
   logic [7:0]  irq_cnt;
   logic        hreadyout, hresp, sys_irq, nmi_req, main_osc_reset_req;
   logic        main_osc_power_off, main_osc_low_power;
   logic        main_osc_high_range, single_ended_clock_select;
   logic [6:0]  cfg [4] = '{7'h48, 7'h24, 7'h30, 7'h10};
   logic [3:0]  pins [4] = '{4'h9, 4'h6, 4'h2, 4'h0};
   int          n_fail, n_tests, n_rq;
   wire         hready = hreadyout;
   wire pll_locked_event = ev[0], regulator_current_limit_event = ev[1];
   wire internal_osc_fail_event = ev[2], regulator_droop_event = ev[4];
   wire supply_droop_event = ev[5], pll_failure_event = ev[6];
   wire nmi_tamper_in = nm[1], nmi_watchdog_zero_in = nm[2];
   wire nmi_watchdog_one_in = nm[3], nmi_power_in = nm[4];
   wire nmi_pin_in = nm[5];
   seic_top #(.MISS_LIMIT(6)) dut (.*);
   seic_cpu_model cpu (.*);
   always #50 core_clk = ~core_clk;
   always @(posedge core_clk) main_osc_tick <= osc_run && !main_osc_tick;
   // sample mid-cycle so edge updates never race the bench
   always @(negedge core_clk) begin
      rdy_n = hreadyout;
      hr_n = hrdata;
      if (main_osc_reset_req === 1'b1) n_rq++;
   end
   task automatic chk(input logic [31:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic pin(input logic s, e);
      chk({31'h0, s}, {31'h0, e});
   endtask
   task automatic wt;
      do @(posedge core_clk); while (rdy_n !== 1'b1);
   endtask
   task automatic bus(input logic w, input logic [5:0] a,
                      input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {26'h0, a};
      wt;
      htrans <= 2'h0;
      hwdata <= d;
      wt;
   endtask
   task automatic rc(input logic [5:0] a, input logic [31:0] e);
      bus(1'b0, a, ZERO_WORD);
      chk(hr_n, e);
   endtask
   task automatic pulse(input logic [6:0] e, input logic [5:0] n);
      ev <= e;
      nm <= n;
      @(posedge core_clk);
      ev <= 7'h00;
      nm <= 6'h00;
      @(posedge core_clk);
   endtask
   task automatic final_report;
      $display("checks %0d failures %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      core_clk = 1'b0;
      srst = 1'b1;
      hsel = 1'b0;
      haddr = ZERO_WORD;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = ZERO_WORD;
      ev = 7'h00;
      nm = 6'h00;
      osc_run = 1'b0;
      repeat (8) @(posedge core_clk);
      srst <= 1'b0;
      rc(OFF_STATUS, ZERO_WORD);
      rc(OFF_NMI, ZERO_WORD);
      rc(OFF_OSC_CFG, 32'h0000_0010);
      rc(6'h18, ZERO_WORD);
      pin(hresp, 1'b0);
      bus(1'b1, OFF_ENABLE, 32'h0000_007F);
      for (int i = 0; i < 7; i++) begin
         if (i == EVT_MAIN_OSCILLATOR_FAIL) continue;
         pulse(7'h01 << i, 6'h00);
         pin(sys_irq, 1'b1);
         rc(OFF_MASKED, ONE << i);
         bus(1'b1, OFF_STATUS, ONE << i);
         rc(OFF_STATUS, ZERO_WORD);
         pin(sys_irq, 1'b0);
      end
      bus(1'b1, OFF_ENABLE, ONE);
      pulse(7'h03, 6'h00);
      rc(OFF_STATUS, 32'h0000_0003);
      rc(OFF_MASKED, ONE);
      bus(1'b1, OFF_VIEW, ONE);
      rc(OFF_STATUS, ONE);
      pin(sys_irq, 1'b1);
      bus(1'b1, OFF_ENABLE, ZERO_WORD);
      rc(OFF_STATUS, ZERO_WORD);
      pin(sys_irq, 1'b0);
      bus(1'b1, OFF_VIEW, ZERO_WORD);
      bus(1'b1, OFF_STATUS, 32'h0000_0003);
      pulse(7'h00, 6'h3E);
      rc(OFF_NMI, 32'h0000_003E);
      pin(nmi_req, 1'b1);
      bus(1'b1, OFF_NMI, 32'h0000_000A);
      rc(OFF_NMI, 32'h0000_0034);
      bus(1'b1, OFF_NMI, 32'h0000_0034);
      rc(OFF_NMI, ZERO_WORD);
      pin(nmi_req, 1'b0);
      foreach (cfg[i]) begin
         bus(1'b1, OFF_OSC_CFG, {25'h0, cfg[i]});
         @(posedge core_clk);
         chk({28'h0, main_osc_power_off, main_osc_low_power,
              main_osc_high_range, single_ended_clock_select},
             {28'h0, pins[i]});
      end
      bus(1'b1, OFF_ENABLE, 32'h0000_0008);
      osc_run <= 1'b1;
      bus(1'b1, OFF_OSC_CFG, 32'h0000_0003);
      repeat (20) @(posedge core_clk);
      pin(sys_irq, 1'b0);
      osc_run <= 1'b0;
      repeat (12) @(posedge core_clk);
      rc(OFF_NMI, ONE);
      rc(OFF_STATUS, 32'h0000_0008);
      pin(sys_irq, 1'b1);
      chk(n_rq, ZERO_WORD);
      bus(1'b1, OFF_STATUS, 32'h0000_0008);
      bus(1'b1, OFF_NMI, ONE);
      osc_run <= 1'b1;
      bus(1'b1, OFF_OSC_CFG, ONE);
      repeat (20) @(posedge core_clk);
      osc_run <= 1'b0;
      repeat (12) @(posedge core_clk);
      chk(n_rq, ONE);
      rc(OFF_STATUS, ZERO_WORD);
      rc(OFF_NMI, ONE);
      bus(1'b1, OFF_NMI, ONE);
      bus(1'b1, OFF_OSC_CFG, ZERO_WORD);
      bus(1'b1, OFF_OSC_CFG, 32'h0000_0009);
      repeat (12) @(posedge core_clk);
      pin(main_osc_power_off, 1'b1);
      rc(OFF_NMI, ZERO_WORD);
      chk(n_rq, ONE);
      chk({24'h0, irq_cnt}, 32'h0000_0008);
      final_report;
   end
   // whole run is well under a thousand cycles
   initial begin
      repeat (3000) @(posedge core_clk);
      n_fail++;
      final_report;
   end
endmodule
